// *** src/adc_serial_core.sv ***
// data-ready flag and serial shift register routing of the converter
// Functional notes
// - ready goes low when a new result sits in the data register
// - ready goes high after a full data word is read, not a partial one
// - unread result: ready high for 500 master clocks before next update
// - ready goes low again once the update has completed
// - ready goes low when calibration finishes, except during an unread-result hold window
// - output shifter loads comm, setup, test or data register per select bits
// - input shifter transfers word to setup, test or comm register per select bits
// - select 00 comm, 01 setup, 10 test, 11 data(16); then back to comm
// - every access begins with a comm write; expected after reset
// - 32 serial clocks with input high returns interface to default
`timescale 1ns/1ps
`default_nettype none
module adc_serial_core #(
	parameter int HOLD = adc_serial_pkg::HOLD_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        sclk_i,
	input  wire logic        din_i,
	input  wire logic        cs_n_i,
	input  wire logic [15:0] result_i,
	input  wire logic        result_valid_i,
	output logic             result_ready_o,
	input  wire logic        cal_done_i,
	output logic             dout_o,
	output logic             result_ready_n_o,
	output logic [7:0]       setup_o,
	output logic [7:0]       test_o,
	output logic [1:0]       gain_o,
	output logic             standby_o
);
	import adc_serial_pkg::*;

	typedef enum {ST_COMM, ST_WRITE, ST_READ} link_state_e;
	typedef enum {RD_IDLE, RD_HOLD} ready_state_e;

	localparam int         PINS     = 3;
	localparam logic [2:0] PIN_IDLE = 3'h7;

	logic [PINS-1:0] pin_raw;
	logic [PINS-1:0] pin_meta;
	logic [PINS-1:0] pin_sync;
	logic            sclk_prev;
	link_state_e     link_state;
	ready_state_e    ready_state;
	logic [7:0]      comm;
	logic [7:0]      setup;
	logic [7:0]      test;
	logic [15:0]     data;
	logic [15:0]     in_shift;
	logic [15:0]     out_shift;
	logic [4:0]      bit_count;
	logic [5:0]      high_count;
	logic [1:0]      register_select;
	logic            result_ready_n;
	logic            unread;
	logic            dout;
	logic [9:0]      hold_count;
	logic [15:0]     pending;
	logic            sclk_s;
	logic            din_s;
	logic            cs_s;
	logic            rise;
	logic            fall;
	logic            resync;
	logic [4:0]      acc_bits;
	logic            last_bit;
	logic            comm_go;
	logic            comm_end;
	logic [7:0]      comm_word;
	logic [1:0]      comm_select;
	logic            comm_read;
	logic            comm_to_comm;
	logic            data_done;
	logic            fifo_valid;
	logic [15:0]     fifo_data;
	logic            result_waiting;
	logic            take_result;
	logic            hold_start;
	logic            hold_end;
	logic            write_data;
	logic            fifo_pop;
	logic            cal_ready;
	logic [15:0]     load_word;

	// synchronised link pins and their edges
	assign pin_raw      = {cs_n_i, din_i, sclk_i};
	assign sclk_s       = pin_sync[0];
	assign din_s        = pin_sync[1];
	assign cs_s         = pin_sync[2];
	assign rise         = sclk_s & ~sclk_prev & ~cs_s;
	assign fall         = ~sclk_s & sclk_prev & ~cs_s;
	assign resync       = rise && din_s && (high_count == 6'(RESYNC_SCLK_HIGH - 1));

	// access length and comm byte decode
	assign acc_bits     = (register_select == SEL_DATA) ? 5'(DATA_BITS) : 5'(COMM_BITS);
	assign last_bit     = (bit_count == acc_bits - 5'h1);
	assign comm_go      = (link_state == ST_COMM) && rise && (bit_count != 5'h0 || !din_s);
	assign comm_end     = comm_go && (bit_count == 5'(COMM_BITS - 1));
	assign comm_word    = {in_shift[6:0], din_s};
	assign comm_select  = comm_word[COMM_POS_RS1:COMM_POS_RS0];
	assign comm_read    = comm_word[COMM_POS_RW];
	assign comm_to_comm = !comm_read && (comm_select == SEL_COMM);
	assign data_done    = (link_state == ST_READ) && rise && last_bit
	                      && (register_select == SEL_DATA);

	// result path: direct update, or hold window before overwriting an unread word
	assign result_waiting = fifo_valid && (ready_state == RD_IDLE);
	assign take_result    = result_waiting && !unread;
	assign hold_start     = result_waiting && unread;
	assign hold_end       = (ready_state == RD_HOLD) && (hold_count == 10'(HOLD - 1));
	assign write_data     = take_result || hold_end;
	assign fifo_pop       = take_result || hold_start;
	assign cal_ready      = cal_done_i && (ready_state == RD_IDLE) && !hold_start;

	// output shifter source, comm read shows ready flag, a zero and bits 5:0 of the byte just written
	assign load_word = (comm_select == SEL_DATA)  ? data
	                 : (comm_select == SEL_SETUP) ? {setup, 8'h00}
	                 : (comm_select == SEL_TEST)  ? {test, 8'h00}
	                 : {result_ready_n, 1'b0, comm_word[COMM_POS_RS1:0], 8'h00};

	result_fifo #(
		.WIDTH(DATA_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.in_data_i  (result_i),
		.in_valid_i (result_valid_i),
		.in_ready_o (result_ready_o),
		.out_data_o (fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop)
	);

	// two flops per pin, reset to the idle level so no false edge follows reset
	generate
		for (genvar p = 0; p < PINS; p++) begin : g_pin_sync
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					pin_meta[p] <= PIN_IDLE[p];
					pin_sync[p] <= PIN_IDLE[p];
				end else begin
					pin_meta[p] <= pin_raw[p];
					pin_sync[p] <= pin_meta[p];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			sclk_prev <= 1'b1;
		else
			sclk_prev <= sclk_s;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			high_count <= 6'h0;
		end else if (rise) begin
			high_count <= (!din_s || resync) ? 6'h0 : high_count + 6'h1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			link_state      <= ST_COMM;
			bit_count       <= 5'h0;
			in_shift        <= 16'h0;
			out_shift       <= 16'h0;
			register_select <= SEL_COMM;
			comm            <= COMM_RESET;
			setup           <= SETUP_RESET;
			test            <= TEST_RESET;
			dout            <= 1'b1;
		end else if (resync) begin
			link_state <= ST_COMM;
			bit_count  <= 5'h0;
		end else begin
			unique case (link_state)
				ST_COMM: begin
					if (comm_go) begin
						in_shift  <= {in_shift[14:0], din_s};
						bit_count <= comm_end ? 5'h0 : bit_count + 5'h1;
					end
					if (comm_end) begin
						comm            <= comm_word;
						register_select <= comm_select;
						if (comm_read) begin
							link_state <= ST_READ;
							out_shift  <= load_word;
						end else if (!comm_to_comm) begin
							link_state <= ST_WRITE;
						end
					end
				end
				ST_WRITE: begin
					if (rise) begin
						in_shift  <= {in_shift[14:0], din_s};
						bit_count <= last_bit ? 5'h0 : bit_count + 5'h1;
						if (last_bit) begin
							link_state <= ST_COMM;
							unique case (register_select)
								SEL_SETUP: setup <= {in_shift[6:0], din_s};
								SEL_TEST:  test  <= {in_shift[6:0], din_s};
								SEL_COMM:  comm  <= {in_shift[6:0], din_s};
								SEL_DATA:  ;
							endcase
						end
					end
				end
				ST_READ: begin
					if (fall || (rise && bit_count == 5'h0))
						dout <= out_shift[15];
					if (rise) begin
						out_shift <= {out_shift[14:0], 1'b0};
						bit_count <= last_bit ? 5'h0 : bit_count + 5'h1;
						if (last_bit)
							link_state <= ST_COMM;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ready_state <= RD_IDLE;
			hold_count  <= 10'h0;
		end else begin
			unique case (ready_state)
				RD_IDLE: begin
					hold_count <= 10'h0;
					if (hold_start)
						ready_state <= RD_HOLD;
				end
				RD_HOLD: begin
					hold_count <= hold_count + 10'h1;
					if (hold_end)
						ready_state <= RD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			data    <= 16'h0;
			pending <= 16'h0;
		end else begin
			if (hold_start)
				pending <= fifo_data;
			if (write_data)
				data <= take_result ? fifo_data : pending;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			unread <= 1'b0;
		else if (write_data)
			unread <= 1'b1;
		else if (data_done)
			unread <= 1'b0;
	end

	// set events win over a finished read in the same cycle
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			result_ready_n <= 1'b1;
		else if (write_data)
			result_ready_n <= 1'b0;
		else if (cal_ready)
			result_ready_n <= 1'b0;
		else if (hold_start)
			result_ready_n <= 1'b1;
		else if (data_done)
			result_ready_n <= 1'b1;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dout_o           <= 1'b1;
			result_ready_n_o <= 1'b1;
			setup_o          <= SETUP_RESET;
			test_o           <= TEST_RESET;
			gain_o           <= 2'h0;
			standby_o        <= 1'b0;
		end else begin
			dout_o           <= dout;
			result_ready_n_o <= result_ready_n;
			setup_o          <= setup;
			test_o           <= test;
			gain_o           <= comm[1:0];
			standby_o        <= comm[2];
		end
	end
endmodule : adc_serial_core
`default_nettype wire

// *** src/adc_serial_pkg.sv ***
// package: constants for the ready flag and serial register routing
package adc_serial_pkg;
	localparam logic [1:0] SEL_COMM  = 2'h0;
	localparam logic [1:0] SEL_SETUP = 2'h1;
	localparam logic [1:0] SEL_TEST  = 2'h2;
	localparam logic [1:0] SEL_DATA  = 2'h3;
	localparam int COMM_BITS = 8;
	localparam int DATA_BITS = 16;
	localparam int RESYNC_SCLK_HIGH = 32;
	localparam int HOLD_MCLK_PERIODS = 500;
	localparam int MCLK_NS = 50;
	localparam int HOLD_CYCLES = HOLD_MCLK_PERIODS;
	localparam logic [7:0] SETUP_RESET = 8'h28;
	localparam logic [7:0] COMM_RESET = 8'h00;
	localparam logic [7:0] TEST_RESET = 8'h00;
	localparam int COMM_POS_WAIT = 7;
	localparam int COMM_POS_RS1 = 5;
	localparam int COMM_POS_RS0 = 4;
	localparam int COMM_POS_RW = 3;
	localparam int FIFO_DEPTH = 8;
endpackage : adc_serial_pkg

// *** src/result_fifo.sv ***
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	wire              do_wr = in_valid_i & in_ready_o;
	wire              do_rd = out_valid_o & out_ready_i;

	assign next_count  = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	assign out_data_o  = mem[rd_ptr];

	always_ff @(posedge clk_i) begin
		if (do_wr)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
			in_ready_o  <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			if (do_wr)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count       <= next_count;
			in_ready_o  <= (next_count != (AW+1)'(DEPTH));
			out_valid_o <= (next_count != '0);
		end
	end
endmodule : result_fifo
`default_nettype wire

// *** testbench/adc_ready_flag_and_shift_routing_test.sv ***
// testbench: ready flag, serial routing and result path
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module adc_ready_flag_and_shift_routing_test;
	import adc_serial_pkg::*;
	logic        clk_i = 1'b0, sys_rst_i = 1'b1, cal_done_i = 1'b0, result_valid_i = 1'b0;
	logic [15:0] result_i = 16'h0000;
	logic [31:0] rx;
	wire logic   sclk, din, cs_n, dout, rdy_n, res_rdy, stby;
	wire logic [7:0] setup, test;
	wire logic [1:0] gain;
	int          n_mismatch = 0, num_checks = 0;
	always #25 clk_i = ~clk_i;
	adc_serial_core #(.HOLD(8)) i_adc_serial_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.sclk_i(sclk), .din_i(din), .cs_n_i(cs_n), .result_i(result_i),
		.result_valid_i(result_valid_i), .result_ready_o(res_rdy), .cal_done_i(cal_done_i),
		.dout_o(dout), .result_ready_n_o(rdy_n), .setup_o(setup), .test_o(test),
		.gain_o(gain), .standby_o(stby));
	host_serial_model i_host_serial_model (.sclk_o(sclk), .din_o(din), .cs_n_o(cs_n),
		.dout_i(dout), .rdy_n_i(rdy_n));
	task automatic results();
		if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	task automatic offer(input logic [15:0] w);
		@(negedge clk_i);
		result_i       = w;
		result_valid_i = 1'b1;
		@(negedge clk_i);
		result_valid_i = 1'b0;
		repeat (30) @(negedge clk_i);
	endtask : offer
	task automatic t_regs();
		`CHK({rdy_n, setup}, {1'b1, SETUP_RESET})
		i_host_serial_model.xfer(32'h0800, 16, 0, rx);
		`CHK(rx[7:0], 8'h88)
		i_host_serial_model.xfer(32'h10a5, 16, 0, rx);
		`CHK(setup, 8'ha5)
		i_host_serial_model.xfer(32'h1800, 16, 0, rx);
		`CHK(rx[7:0], 8'ha5)
		i_host_serial_model.xfer(32'h203c, 16, 0, rx);
		`CHK(test, 8'h3c)
		i_host_serial_model.xfer(32'h07, 8, 0, rx);
		`CHK({gain, stby}, 3'h7)
	endtask : t_regs
	task automatic t_data();
		offer(16'hc3a5);
		`CHK(rdy_n, 1'b0)
		i_host_serial_model.xfer(32'h380000, 24, 1, rx);
		`CHK(rx[15:0], 16'hc3a5)
		`CHK(rdy_n, 1'b1)
	endtask : t_data
	task automatic t_partial();
		offer(16'h5a0f);
		i_host_serial_model.xfer(32'h3800, 16, 1, rx);
		`CHK({rdy_n, rx[7:0]}, 9'h05a)
		i_host_serial_model.xfer(32'hffffffff, 32, 0, rx);
		i_host_serial_model.xfer(32'h1042, 16, 0, rx);
		`CHK(setup, 8'h42)
	endtask : t_partial
	task automatic t_hold();
		offer(16'h1111);
		offer(16'h2222);
		`CHK(rdy_n, 1'b0)
		i_host_serial_model.xfer(32'h380000, 24, 1, rx);
		`CHK(rx[15:0], 16'h2222)
		@(negedge clk_i);
		cal_done_i = 1'b1;
		@(negedge clk_i);
		cal_done_i = 1'b0;
		repeat (4) @(negedge clk_i);
		`CHK(rdy_n, 1'b0)
	endtask : t_hold
	initial begin
		repeat (4) @(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		t_regs();
		t_data();
		t_partial();
		t_hold();
		results();
	end
	initial begin
		#2000000;
		n_mismatch++;
		results();
	end
endmodule : adc_ready_flag_and_shift_routing_test
`default_nettype wire

// *** testbench/adc_serial_monitor.sv ***
// checker: ready flag and serial routing properties
`timescale 1ns/1ps
`default_nettype none
module adc_serial_monitor #(
	parameter int HOLD = 500
) (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        sclk_i,
	input wire logic        din_i,
	input wire logic        cs_n_i,
	input wire logic [15:0] result_i,
	input wire logic        result_valid_i,
	input wire logic        result_ready_o,
	input wire logic        cal_done_i,
	input wire logic        dout_o,
	input wire logic        result_ready_n_o,
	input wire logic [7:0]  setup_o,
	input wire logic [7:0]  test_o,
	input wire logic [1:0]  gain_o,
	input wire logic        standby_o
);
	int   hi_cnt;
	logic hold_mode;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// cycles of ready high, and whether the rise came outside a frame
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hi_cnt    <= 0;
			hold_mode <= 1'b0;
		end else begin
			hi_cnt    <= result_ready_n_o ? hi_cnt + 1 : 0;
			hold_mode <= ($rose(result_ready_n_o) && cs_n_i) || (hold_mode && result_ready_n_o);
		end
	end
	chk_reset_values: assert property ($fell(sys_rst_i) |-> result_ready_n_o &&
		setup_o == 8'h28 && test_o == 8'h00 && gain_o == 2'h0 && !standby_o) else $error("reset");
	chk_cal_ready: assert property (cal_done_i |-> ##[1:4] !result_ready_n_o)
		else $error("cal flag");
	chk_hold_span: assert property ($fell(result_ready_n_o) && hold_mode |->
		hi_cnt >= HOLD - 2 && hi_cnt <= HOLD + 3) else $error("hold span");
	chk_update_ready: assert property (result_valid_i && result_ready_o &&
		result_ready_n_o && !hold_mode && cs_n_i |-> ##[1:4] !result_ready_n_o) else $error("new word");
	chk_setup_framed: assert property ($changed(setup_o) |-> !$past(cs_n_i))
		else $error("setup write");
	chk_comm_framed: assert property (!$stable({gain_o, standby_o}) |-> !$past(cs_n_i))
		else $error("comm write");
	chk_test_framed: assert property ($changed(test_o) |-> $past(!cs_n_i, 1))
		else $error("test write");
	chk_dout_steady: assert property ($changed(dout_o) |-> !$past(sclk_i, 3))
		else $error("dout moved");
	cover property ($fell(result_ready_n_o) && hold_mode);
	cover property (cal_done_i);
	cover property ($changed(setup_o));
	cover property ($rose(result_ready_n_o) && !cs_n_i);
endmodule : adc_serial_monitor
bind adc_serial_core adc_serial_monitor #(.HOLD(HOLD)) i_adc_serial_monitor (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .din_i(din_i), .cs_n_i(cs_n_i),
	.result_i(result_i), .result_valid_i(result_valid_i), .result_ready_o(result_ready_o),
	.cal_done_i(cal_done_i), .dout_o(dout_o), .result_ready_n_o(result_ready_n_o),
	.setup_o(setup_o), .test_o(test_o), .gain_o(gain_o), .standby_o(standby_o));
`default_nettype wire

// *** testbench/host_serial_model.sv ***
// host model: controller side of the serial link
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
	output logic      sclk_o,
	output logic      din_o,
	output logic      cs_n_o,
	input  wire logic dout_i,
	input  wire logic rdy_n_i
);
	initial begin
		sclk_o = 1'b1;
		din_o  = 1'b1;
		cs_n_o = 1'b1;
	end
	// one framed transfer of n bits, msb first, comm byte leading
	task automatic xfer(input logic [31:0] tx, input int n, input bit rd, output logic [31:0] rx);
		rx = '0;
		if (rd) wait (!rdy_n_i);
		cs_n_o = 1'b0;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o = 1'b0;
			din_o  = tx[i];
			#200;
			sclk_o = 1'b1;
			#200;
			rx = {rx[30:0], dout_i};
		end
		#400;
		cs_n_o = 1'b1;
		din_o  = ~din_o;
		#200;
	endtask : xfer
endmodule : host_serial_model
`default_nettype wire
